// file: dv/nvac_checker.sv
// Concurrent checks on the register port of the EEPROM access controller.
`timescale 1ns/1ps
`default_nettype none

module nvac_checker
    import nvac_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] sfr_sect_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       sfr_rvalid_out,
    input wire logic       done_irq_out
);
    // ****************
    // Helper state
    // ****************
    // Read permit is never cleared by hardware, so its written value is a full model.
    logic fetch_perm_q;
    logic ctl_sel;
    assign ctl_sel = sfr_sect_in == NV_SECT_INDIRECT && sfr_addr_in == NV_OFS_CTL;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            fetch_perm_q <= 1'b0;
        else if (sfr_wr_in && ctl_sel)
            fetch_perm_q <= sfr_wdata_in[NV_B_FPERM];
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence ctl_rd;
        sfr_rd_in && ctl_sel && !sfr_wr_in;
    endsequence
    sequence go_no_perm;
        sfr_wr_in && ctl_sel && sfr_wdata_in[NV_B_FGO] && !fetch_perm_q;
    endsequence

    // ****************
    // Assertions
    // ****************
    chk_rvalid_follow: assert property (sfr_rd_in |=> sfr_rvalid_out)
        else $error("read strobe not answered next cycle");
    chk_rvalid_only: assert property (!sfr_rd_in |=> !sfr_rvalid_out)
        else $error("read valid without a read");
    chk_hi_pad_zero: assert property (sfr_rd_in && sfr_sect_in == NV_SECT_DIRECT
        && sfr_addr_in == NV_OFS_ADDR_HI |=> sfr_rdata_out[7:2] == 6'h00)
        else $error("high address pad bits not zero");
    chk_unmapped_zero: assert property (sfr_rd_in && ((sfr_sect_in == NV_SECT_INDIRECT)
        != (sfr_addr_in == NV_OFS_CTL)) |=> sfr_rdata_out == NV_BYTE_ZERO)
        else $error("control decoded at a wrong place");
    chk_rdata_hold: assert property (!sfr_rvalid_out && !$past(rst_in)
        |-> $stable(sfr_rdata_out))
        else $error("read data changed without a read");
    chk_go_refused: assert property (go_no_perm ##1 ctl_rd
        |=> !sfr_rdata_out[NV_B_FGO])
        else $error("read go accepted without permit");
    chk_perm_readback: assert property (ctl_rd
        |=> sfr_rdata_out[NV_B_FPERM] == fetch_perm_q)
        else $error("read permit readback wrong");
    chk_irq_pulse: assert property (done_irq_out |=> !done_irq_out)
        else $error("completion pulse longer than one cycle");
endmodule

bind nvac_top nvac_checker u_chk (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .sfr_sect_in    (sfr_sect_in),
    .sfr_addr_in    (sfr_addr_in),
    .sfr_wr_in      (sfr_wr_in),
    .sfr_rd_in      (sfr_rd_in),
    .sfr_wdata_in   (sfr_wdata_in),
    .sfr_rdata_out  (sfr_rdata_out),
    .sfr_rvalid_out (sfr_rvalid_out),
    .done_irq_out   (done_irq_out)
);

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the EEPROM access controller.
`timescale 1ns/1ps
`default_nettype none

module tb
    import nvac_pkg::*;
;
    // Short cycle counts keep the run small; expectations derive from them.
    localparam int WF = 20;
    localparam int SF = 14;
    localparam int WS = 24;
    localparam int SS = 18;
    localparam logic [7:0] DI = NV_SECT_DIRECT;
    localparam logic [7:0] IN = NV_SECT_INDIRECT;
    logic       clk_in;
    logic       rst_in;
    logic       sfr_wr_in;
    logic       sfr_rd_in;
    logic [7:0] sfr_sect_in;
    logic [7:0] sfr_addr_in;
    logic [7:0] sfr_wdata_in;
    logic [7:0] sfr_rdata_out;
    logic       sfr_rvalid_out;
    logic       done_irq_out;
    int         n_fail;
    int         checks_done;
    int         cyc;
    logic [7:0] v;

    nvac_top #(.WIPE_FAST_CYC(WF), .STORE_FAST_CYC(SF), .WIPE_SLOW_CYC(WS),
        .STORE_SLOW_CYC(SS)) dut (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .sfr_sect_in    (sfr_sect_in),
        .sfr_addr_in    (sfr_addr_in),
        .sfr_wr_in      (sfr_wr_in),
        .sfr_rd_in      (sfr_rd_in),
        .sfr_wdata_in   (sfr_wdata_in),
        .sfr_rdata_out  (sfr_rdata_out),
        .sfr_rvalid_out (sfr_rvalid_out),
        .done_irq_out   (done_irq_out)
    );

    // ****************
    // Bus tasks
    // ****************
    task automatic close_out;
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes stay up between back-to-back accesses, so no strobe is set twice in one step.
    task automatic wr(input logic [7:0] s, input logic [7:0] a, input logic [7:0] d);
        sfr_sect_in = s;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_rd_in = 1'b0;
        sfr_wr_in = 1'b1;
        @(posedge clk_in);
        #1;
    endtask
    // Drops both strobes before any wait, so a held write is never repeated.
    task automatic quiet;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] s, input logic [7:0] a, output logic [7:0] q);
        sfr_sect_in = s;
        sfr_addr_in = a;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b1;
        @(posedge clk_in);
        #1;
        q = sfr_rdata_out;
        chk({7'h00, sfr_rvalid_out}, 8'h01);
    endtask
    task automatic rdc(input logic [7:0] s, input logic [7:0] a, input logic [7:0] e);
        rd(s, a, v);
        chk(v, e);
    endtask
    task automatic ctl(input logic [7:0] d);
        wr(IN, NV_OFS_CTL, d);
    endtask
    // A read is refused until the permit stands, so the permit goes first.
    task automatic fetch(input logic [7:0] m, input logic [7:0] e, input bit first);
        int i;
        if (first)
            ctl(m | 8'h02);
        ctl(m | 8'h03);
        for (i = 0; i < 10; i++)
        begin
            rd(IN, NV_OFS_CTL, v);
            if (v[NV_B_FGO] === 1'b0)
                break;
        end
        chk(8'(i), 8'h03);
        rdc(DI, NV_OFS_DATA, e);
    endtask
    task automatic timed(input logic [7:0] p, input logic [7:0] g, input int e);
        int n;
        ctl(p);
        ctl(g);
        quiet;
        n = 0;
        while (done_irq_out !== 1'b1 && n < 300)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk({7'h00, n == e + 1}, 8'h01);
        rdc(IN, NV_OFS_CTL, g & 8'h90);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs;
        rdc(DI, NV_OFS_ADDR_LO, 8'h00);
        rdc(DI, NV_OFS_ADDR_HI, 8'h00);
        rdc(DI, NV_OFS_DATA, 8'h00);
        rdc(IN, NV_OFS_CTL, 8'h00);
        rdc(DI, NV_OFS_CTL, 8'h00);
        rdc(IN, NV_OFS_ADDR_LO, 8'h00);
        wr(DI, NV_OFS_ADDR_HI, 8'hFF);
        rdc(DI, NV_OFS_ADDR_HI, 8'h03);
    endtask
    task automatic t_refuse;
        bit seen;
        ctl(8'h00);
        ctl(8'h04);
        rdc(IN, NV_OFS_CTL, 8'h00);
        ctl(8'h20);
        rdc(IN, NV_OFS_CTL, 8'h00);
        ctl(8'h01);
        rdc(IN, NV_OFS_CTL, 8'h00);
        quiet;
        seen = 1'b0;
        repeat (40)
        begin
            @(posedge clk_in);
            #1;
            seen = seen | (done_irq_out !== 1'b0);
        end
        chk({7'h00, seen}, 8'h00);
    endtask
    task automatic t_byte;
        wr(DI, NV_OFS_ADDR_HI, 8'h01);
        wr(DI, NV_OFS_ADDR_LO, 8'h23);
        wr(DI, NV_OFS_DATA, 8'hA5);
        timed(8'h08, 8'h0C, SF);
        wr(DI, NV_OFS_DATA, 8'h00);
        fetch(8'h00, 8'hA5, 1'b1);
        rdc(DI, NV_OFS_DATA, 8'hA5);
        timed(8'hC0, 8'hE0, WS);
        fetch(8'h00, 8'h00, 1'b1);
        wr(DI, NV_OFS_DATA, 8'h3C);
        timed(8'h88, 8'h8C, SS);
        fetch(8'h00, 8'h3C, 1'b1);
        timed(8'h40, 8'h60, WF);
        fetch(8'h00, 8'h00, 1'b1);
    endtask
    task automatic t_page;
        int i;
        ctl(8'h10);
        wr(DI, NV_OFS_ADDR_LO, 8'hF0);
        for (i = 0; i < 17; i++)
            wr(DI, NV_OFS_DATA, 8'h40 + 8'(i));
        rdc(DI, NV_OFS_ADDR_LO, 8'hFF);
        rdc(DI, NV_OFS_ADDR_HI, 8'h01);
        timed(8'h18, 8'h1C, SF + 15);
        wr(DI, NV_OFS_ADDR_LO, 8'hF0);
        for (i = 0; i < 16; i++)
        begin
            fetch(8'h10, 8'h40 + 8'(i), i == 0);
            rdc(DI, NV_OFS_ADDR_LO, 8'hF0 + 8'((i < 15) ? i + 1 : 15));
        end
        // Page erase clears only the two tagged slots; their neighbours keep their bytes.
        ctl(8'h10);
        wr(DI, NV_OFS_ADDR_LO, 8'hF4);
        wr(DI, NV_OFS_DATA, 8'h77);
        wr(DI, NV_OFS_DATA, 8'h77);
        timed(8'h50, 8'h70, WF + 15);
        wr(DI, NV_OFS_ADDR_LO, 8'hF3);
        fetch(8'h10, 8'h43, 1'b1);
        fetch(8'h10, 8'h00, 1'b0);
        fetch(8'h10, 8'h00, 1'b0);
        fetch(8'h10, 8'h46, 1'b0);
    endtask

    // ****************
    // Clock, reset, run
    // ****************
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            close_out;
        end
    end
    initial
    begin
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        rst_in = 1'b1;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
        sfr_sect_in = 8'h00;
        sfr_addr_in = 8'h00;
        sfr_wdata_in = 8'h00;
        repeat (6) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_regs;
        t_refuse;
        t_byte;
        t_page;
        close_out;
    end
endmodule

`default_nettype wire

// file: hw/nvac_mem.sv
// Byte-wide storage array with a registered read port.
`timescale 1ns/1ps
`default_nettype none

module nvac_mem
    import nvac_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 we_in,
    input  wire logic [NV_ADDR_W-1:0] addr_in,
    input  wire logic [7:0]           wdata_in,
    output var  logic [7:0]           rdata_out
);

    // Contents are not reset, as in a real nonvolatile array.
    logic [7:0] cells [NV_ARRAY_BYTES];

    always_ff @(posedge clk_in)
    begin
        if (we_in)
        begin
            cells[addr_in] <= wdata_in;
        end
        rdata_out <= cells[addr_in];
    end

endmodule

`default_nettype wire

// file: hw/nvac_pkg.sv
// Constants, types and state layout for the data EEPROM access controller.
package nvac_pkg;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    localparam logic [7:0] NV_SECT_DIRECT   = 8'h00;
    localparam logic [7:0] NV_SECT_INDIRECT = 8'h01;
    localparam logic [7:0] NV_OFS_CTL       = 8'h40;
    localparam logic [7:0] NV_OFS_ADDR_LO   = 8'h2C;
    localparam logic [7:0] NV_OFS_ADDR_HI   = 8'h2D;
    localparam logic [7:0] NV_OFS_DATA      = 8'h2E;

    // ****************************************************************
    // Control register fields and reset values
    // ****************************************************************
    localparam int NV_B_SLOW   = 7;
    localparam int NV_B_WPERM  = 6;
    localparam int NV_B_WGO    = 5;
    localparam int NV_B_MODE   = 4;
    localparam int NV_B_SPERM  = 3;
    localparam int NV_B_SGO    = 2;
    localparam int NV_B_FPERM  = 1;
    localparam int NV_B_FGO    = 0;
    localparam int NV_HI_MSB   = 1;
    localparam int NV_HI_PAD   = 6;
    localparam logic [7:0] NV_BYTE_ZERO = 8'h00;
    localparam logic [3:0] NV_NIB_ZERO  = 4'h0;
    localparam logic [3:0] NV_NIB_LAST  = 4'hF;
    localparam int NV_PAGE_BYTES = 16;
    localparam int NV_ARRAY_BYTES = 1024;
    localparam int NV_ADDR_W = 10;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int NV_CLK_NS        = 8;
    localparam int NV_WIPE_FAST_NS  = 3_200_000;
    localparam int NV_STORE_FAST_NS = 2_200_000;
    localparam int NV_WIPE_SLOW_NS  = 3_700_000;
    localparam int NV_STORE_SLOW_NS = 3_000_000;
    localparam int NV_TIMER_W       = 20;
    localparam logic [NV_TIMER_W-1:0] NV_CNT_ZERO = 20'h0_0000;
    localparam logic [NV_TIMER_W-1:0] NV_CNT_ONE  = 20'h0_0001;
    localparam logic [NV_TIMER_W-1:0] NV_READ_LAST = 20'h0_0002;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [3:0] {
        NV_IDLE   = 4'b0001,
        NV_READ   = 4'b0010,
        NV_TIME   = 4'b0100,
        NV_COMMIT = 4'b1000
    } nvac_fsm_t;

    typedef struct packed {
        nvac_fsm_t                      fsm;
        logic [7:0]                     ctl;
        logic [7:0]                     addr_lo;
        logic [NV_HI_MSB:0]             addr_hi;
        logic [7:0]                     data;
        logic [NV_TIMER_W-1:0]          cnt;
        logic [3:0]                     idx;
        logic                           op_wipe;
        logic [NV_PAGE_BYTES-1:0][7:0]  pbuf;
        logic [NV_PAGE_BYTES-1:0]       tag;
        logic                           pfull;
        logic [7:0]                     rdata;
        logic                           rvalid;
        logic                           irq;
    } nvac_regs_t;

endpackage

// file: hw/nvac_top.sv
// Register interface and sequencer of the data EEPROM access controller.
//
// Notes on behaviour
// - Array address is low register plus two high bits; upper high bits read zero.
// - Control register decodes only at offset 40H with pointer high byte 01H.
// - Fast timing: erase 3.2ms, write 2.2ms.
// - Slow timing: erase 3.7ms, write 3.0ms.
// - Erase permit gates erases and clears itself when an erase ends.
// - Erase go starts only with permit already set; clears at erase end.
// - Mode bit picks byte or 16-byte page operation.
// - Write permit gates writes and clears itself when a write ends.
// - Write go starts only with permit already set; clears at write end.
// - Read permit gates reads.
// - Read go starts only with read permit set; clears at read end.
// - Byte read end clears read go and loads the data register.
// - Data register holds a read value until another read or write.
// - Page read end clears go, loads data, advances address by one.
// - Repeated page read go uses the advanced address.
// - Page mode keeps upper six address bits, steps only the low nibble.
// - Low nibble saturates at 0FH and never wraps.
// - Address and data registers sit directly in the first sector.
// - Array holds 1024 bytes, reached only through these registers.
// - Erase or write completion raises an interrupt request pulse.
`timescale 1ns/1ps
`default_nettype none

module nvac_top
    import nvac_pkg::*;
#(
    parameter int WIPE_FAST_CYC  = NV_WIPE_FAST_NS / NV_CLK_NS,
    parameter int STORE_FAST_CYC = NV_STORE_FAST_NS / NV_CLK_NS,
    parameter int WIPE_SLOW_CYC  = NV_WIPE_SLOW_NS / NV_CLK_NS,
    parameter int STORE_SLOW_CYC = NV_STORE_SLOW_NS / NV_CLK_NS
)
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] sfr_sect_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            sfr_rvalid_out,
    output logic            done_irq_out
);

    // ****************************************************************
    // Cycle targets
    // ****************************************************************
    localparam logic [NV_TIMER_W-1:0] WIPE_F_LAST  = NV_TIMER_W'(WIPE_FAST_CYC - 1);
    localparam logic [NV_TIMER_W-1:0] STORE_F_LAST = NV_TIMER_W'(STORE_FAST_CYC - 1);
    localparam logic [NV_TIMER_W-1:0] WIPE_S_LAST  = NV_TIMER_W'(WIPE_SLOW_CYC - 1);
    localparam logic [NV_TIMER_W-1:0] STORE_S_LAST = NV_TIMER_W'(STORE_SLOW_CYC - 1);

    nvac_regs_t              s;
    nvac_regs_t              n;
    logic                    mem_we;
    logic [NV_ADDR_W-1:0]    mem_addr;
    logic [7:0]              mem_wdata;
    logic [7:0]              mem_rdata;
    logic [NV_TIMER_W-1:0]   tgt;
    logic                    wr_direct;
    logic                    wr_ctl;
    logic                    rd_direct;
    logic                    rd_ctl;

    // ****************************************************************
    // Storage array
    // ****************************************************************
    nvac_mem u_mem
    (
        .clk_in    (clk_in),
        .we_in     (mem_we),
        .addr_in   (mem_addr),
        .wdata_in  (mem_wdata),
        .rdata_out (mem_rdata)
    );

    // The cycle length is sampled live; software must not alter the
    // select bit while a cycle runs.
    always_comb
    begin
        if (s.op_wipe)
        begin
            tgt = s.ctl[NV_B_SLOW] ? WIPE_S_LAST : WIPE_F_LAST;
        end
        else
        begin
            tgt = s.ctl[NV_B_SLOW] ? STORE_S_LAST : STORE_F_LAST;
        end
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign wr_direct = sfr_wr_in && (sfr_sect_in == NV_SECT_DIRECT);
    assign rd_direct = sfr_rd_in && (sfr_sect_in == NV_SECT_DIRECT);
    assign wr_ctl    = sfr_wr_in && (sfr_sect_in == NV_SECT_INDIRECT)
                       && (sfr_addr_in == NV_OFS_CTL);
    assign rd_ctl    = sfr_rd_in && (sfr_sect_in == NV_SECT_INDIRECT)
                       && (sfr_addr_in == NV_OFS_CTL);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        n         = s;
        n.rvalid  = 1'b0;
        n.irq     = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = {s.addr_hi, s.addr_lo};
        mem_wdata = s.data;

        unique case (s.fsm)
            NV_IDLE:
            begin
                n.cnt = NV_CNT_ZERO;
            end
            NV_READ:
            begin
                n.cnt = s.cnt + NV_CNT_ONE;
                if (s.cnt == NV_READ_LAST)
                begin
                    n.data          = mem_rdata;
                    n.ctl[NV_B_FGO] = 1'b0;
                    n.fsm           = NV_IDLE;
                    if (s.ctl[NV_B_MODE] && (s.addr_lo[3:0] != NV_NIB_LAST))
                    begin
                        n.addr_lo[3:0] = s.addr_lo[3:0] + 4'h1;
                    end
                end
            end
            NV_TIME:
            begin
                n.cnt = s.cnt + NV_CNT_ONE;
                if (s.cnt >= tgt)
                begin
                    n.fsm = NV_COMMIT;
                    n.idx = NV_NIB_ZERO;
                end
            end
            NV_COMMIT:
            begin
                // Page mode walks the buffer and touches only tagged bytes.
                if (s.ctl[NV_B_MODE])
                begin
                    mem_we    = s.tag[s.idx];
                    mem_addr  = {s.addr_hi, s.addr_lo[7:4], s.idx};
                    mem_wdata = s.op_wipe ? NV_BYTE_ZERO : s.pbuf[s.idx];
                end
                else
                begin
                    mem_we    = 1'b1;
                    mem_wdata = s.op_wipe ? NV_BYTE_ZERO : s.data;
                end
                n.idx = s.idx + 4'h1;
                if (!s.ctl[NV_B_MODE] || (s.idx == NV_NIB_LAST))
                begin
                    n.fsm = NV_IDLE;
                    n.irq = 1'b1;
                    if (s.op_wipe)
                    begin
                        n.ctl[NV_B_WGO]   = 1'b0;
                        n.ctl[NV_B_WPERM] = 1'b0;
                    end
                    else
                    begin
                        n.ctl[NV_B_SGO]   = 1'b0;
                        n.ctl[NV_B_SPERM] = 1'b0;
                    end
                end
            end
        endcase

        // Software writes land after the hardware updates, so a permit bit
        // that software sets in the cycle of a hardware clear survives; a go bit is refused then.
        if (wr_direct && (sfr_addr_in == NV_OFS_ADDR_LO))
        begin
            n.addr_lo = sfr_wdata_in;
            n.pfull   = 1'b0;
        end
        if (wr_direct && (sfr_addr_in == NV_OFS_ADDR_HI))
        begin
            n.addr_hi = sfr_wdata_in[NV_HI_MSB:0];
            n.pfull   = 1'b0;
        end
        if (wr_direct && (sfr_addr_in == NV_OFS_DATA))
        begin
            n.data = sfr_wdata_in;
            // Once the last slot is filled, further page loads are dropped.
            if (s.ctl[NV_B_MODE] && !s.pfull && (s.fsm == NV_IDLE))
            begin
                n.pbuf[s.addr_lo[3:0]] = sfr_wdata_in;
                n.tag[s.addr_lo[3:0]]  = 1'b1;
                if (s.addr_lo[3:0] == NV_NIB_LAST)
                begin
                    n.pfull = 1'b1;
                end
                else
                begin
                    n.addr_lo[3:0] = s.addr_lo[3:0] + 4'h1;
                end
            end
        end
        if (wr_ctl)
        begin
            n.ctl[NV_B_SLOW]  = sfr_wdata_in[NV_B_SLOW];
            n.ctl[NV_B_MODE]  = sfr_wdata_in[NV_B_MODE];
            n.ctl[NV_B_WPERM] = sfr_wdata_in[NV_B_WPERM];
            n.ctl[NV_B_SPERM] = sfr_wdata_in[NV_B_SPERM];
            n.ctl[NV_B_FPERM] = sfr_wdata_in[NV_B_FPERM];
            if (s.fsm == NV_IDLE)
            begin
                if (sfr_wdata_in[NV_B_WGO] && s.ctl[NV_B_WPERM])
                begin
                    n.ctl[NV_B_WGO] = 1'b1;
                    n.op_wipe       = 1'b1;
                    n.fsm           = NV_TIME;
                    n.cnt           = NV_CNT_ZERO;
                end
                else if (sfr_wdata_in[NV_B_SGO] && s.ctl[NV_B_SPERM])
                begin
                    n.ctl[NV_B_SGO] = 1'b1;
                    n.op_wipe       = 1'b0;
                    n.fsm           = NV_TIME;
                    n.cnt           = NV_CNT_ZERO;
                end
                else if (sfr_wdata_in[NV_B_FGO] && s.ctl[NV_B_FPERM])
                begin
                    n.ctl[NV_B_FGO] = 1'b1;
                    n.fsm           = NV_READ;
                    n.cnt           = NV_CNT_ZERO;
                end
            end
        end

        // An erase or write permit falling from one to zero empties the page buffer.
        if ((s.ctl[NV_B_WPERM] && !n.ctl[NV_B_WPERM])
            || (s.ctl[NV_B_SPERM] && !n.ctl[NV_B_SPERM]))
        begin
            n.pbuf  = '0;
            n.tag   = '0;
            n.pfull = 1'b0;
        end

        if (sfr_rd_in)
        begin
            n.rvalid = 1'b1;
            n.rdata  = NV_BYTE_ZERO;
            if (rd_ctl)
            begin
                n.rdata = s.ctl;
            end
            else if (rd_direct && (sfr_addr_in == NV_OFS_ADDR_LO))
            begin
                n.rdata = s.addr_lo;
            end
            else if (rd_direct && (sfr_addr_in == NV_OFS_ADDR_HI))
            begin
                n.rdata = {{NV_HI_PAD{1'b0}}, s.addr_hi};
            end
            else if (rd_direct && (sfr_addr_in == NV_OFS_DATA))
            begin
                n.rdata = s.data;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s     <= '0;
            s.fsm <= NV_IDLE;
        end
        else
        begin
            s <= n;
        end
    end

    assign sfr_rdata_out  = s.rdata;
    assign sfr_rvalid_out = s.rvalid;
    assign done_irq_out   = s.irq;

endmodule

`default_nettype wire
